// ==== rtl/tcc_top.v ====
// 16-bit timer with two capture/compare registers behind an apb slave
`timescale 1ns/1ps
`default_nettype none
`include "tcc_timer_map.vh"

module tcc_top #(
    parameter CW = 16
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        ce,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        edge_input_a,
    output wire        irq
);

    // ======================================================================
    // functions
    // registers narrower than the bus read back with zero upper bits
    function [31:0] pad_word;
        input [CW-1:0] v;
        begin
            pad_word = {{(32-CW){1'b0}}, v};
        end
    endfunction

    // offsets outside the map answer with pslverr
    function is_mapped;
        input [7:0] a;
        begin
            case (a)
                `TCC_OFS_MODE:     is_mapped = 1'b1;
                `TCC_OFS_CC_A:     is_mapped = 1'b1;
                `TCC_OFS_CC_B:     is_mapped = 1'b1;
                `TCC_OFS_COUNT:    is_mapped = 1'b1;
                `TCC_OFS_IRQ_STAT: is_mapped = 1'b1;
                `TCC_OFS_IRQ_MASK: is_mapped = 1'b1;
                default:           is_mapped = 1'b0;
            endcase
        end
    endfunction

    // ======================================================================
    // state
    // next values end in _d and are formed in the processes below
    reg [`TCC_MODE_W-1:0] mode_q;
    reg [`TCC_MODE_W-1:0] mode_d;
    reg [CW-1:0]          count_q;
    reg [CW-1:0]          count_d;
    reg                   wrapped_q;
    reg                   wrapped_d;
    reg [`TCC_IRQ_W-1:0]  stat_q;
    reg [`TCC_IRQ_W-1:0]  stat_d;
    reg [`TCC_IRQ_W-1:0]  mask_q;
    reg [`TCC_IRQ_W-1:0]  mask_d;
    reg                   irq_q;
    reg                   irq_d;
    reg [31:0]            prdata_q;
    reg [31:0]            prdata_d;
    reg                   pready_q;
    reg                   pready_d;
    reg                   pslverr_q;
    reg                   pslverr_d;

    // bus decode and channel results
    wire [1:0]    op_mode;
    wire          running;
    wire          cnt_edge;
    wire          acc;
    wire          answer;
    wire          wr_done;
    reg           wr_mode;
    reg           wr_cc_a;
    reg           wr_cc_b;
    reg           wr_stat;
    reg           wr_mask;
    wire [CW-1:0] cc_a_val;
    wire [CW-1:0] cc_b_val;
    wire          match_a;
    wire          match_b_irq;
    wire          cap_a;
    wire          cap_b;
    wire [`TCC_IRQ_W-1:0] events;

    assign op_mode = {mode_q[`TCC_MODE_OP_HI], mode_q[`TCC_MODE_OP_LO]};
    // any non-zero mode counts; the modes differ only in what clears the count
    assign running = (op_mode != `TCC_OP_STOP);

    // ======================================================================
    // apb slave: one wait state, pready from a flop
    assign acc     = psel & penable;
    // the answer waits one cycle so prdata and pready both leave flops
    assign answer  = acc & ~pready_q;
    assign wr_done = acc & pready_q & pwrite;

    // ======================================================================
    // register write strobes: at most one per transfer
    always @* begin
        wr_mode = 1'b0;
        wr_cc_a = 1'b0;
        wr_cc_b = 1'b0;
        wr_stat = 1'b0;
        wr_mask = 1'b0;
        if (wr_done) begin
            // count is read only and unmapped offsets raise no strobe
            case (paddr)
                `TCC_OFS_MODE:     wr_mode = 1'b1;
                `TCC_OFS_CC_A:     wr_cc_a = 1'b1;
                `TCC_OFS_CC_B:     wr_cc_b = 1'b1;
                `TCC_OFS_IRQ_STAT: wr_stat = 1'b1;
                `TCC_OFS_IRQ_MASK: wr_mask = 1'b1;
                default:           wr_mode = 1'b0;
            endcase
        end
    end

    // ======================================================================
    // edge input and capture/compare channels
    // the pin is asynchronous: nothing reads it before two flops
    tcc_sync u_sync_a (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .pin     (edge_input_a),
        .rise    (cnt_edge)
    );

    // the timer ignores the edge pin while stopped
    tcc_ccr #(.W(CW)) u_cc_a (
        .pclk     (pclk),
        .presetn  (presetn),
        .ce       (ce),
        .wr_en    (wr_cc_a),
        .wdata    (pwdata[CW-1:0]),
        .cap_mode (mode_q[`TCC_MODE_CAP_A]),
        .cap_trig (cnt_edge & running),
        .count    (count_q),
        .running  (running),
        .wrapped  (wrapped_q),
        .value    (cc_a_val),
        .match    (match_a),
        .captured (cap_a)
    );

    // register b is written freely; safe update is software's job
    tcc_ccr #(.W(CW)) u_cc_b (
        .pclk     (pclk),
        .presetn  (presetn),
        .ce       (ce),
        .wr_en    (wr_cc_b),
        .wdata    (pwdata[CW-1:0]),
        .cap_mode (mode_q[`TCC_MODE_CAP_B]),
        .cap_trig (cnt_edge & running),
        .count    (count_q),
        .running  (running),
        .wrapped  (wrapped_q),
        .value    (cc_b_val),
        .match    (match_b_irq),
        .captured (cap_b)
    );

    // ======================================================================
    // counter
    // the count advances only with ce high; stopped, it sits at zero
    always @* begin
        count_d   = count_q;
        wrapped_d = wrapped_q;
        if (!running) begin
            // stopped: hold at zero, register b may hold anything
            count_d   = `TCC_CNT_ZERO;
            wrapped_d = 1'b0;
        end else if ((op_mode == `TCC_OP_CLR_EDGE) && cnt_edge) begin
            // a clear is not an overflow: zero must not match b until the next wrap
            count_d   = `TCC_CNT_ZERO;
            wrapped_d = 1'b0;
        end else if ((op_mode == `TCC_OP_CLR_MATCH) && match_a) begin
            count_d   = `TCC_CNT_ZERO;
            wrapped_d = 1'b0;
        end else begin
            count_d = count_q + `TCC_CNT_ONE;
            if (count_q == `TCC_CNT_MAX) begin
                wrapped_d = 1'b1;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q   <= `TCC_CNT_ZERO;
            wrapped_q <= 1'b0;
        end else if (ce) begin
            count_q   <= count_d;
            wrapped_q <= wrapped_d;
        end
    end

    // ======================================================================
    // interrupt sources, in status bit order
    assign events = {cap_b, cap_a, match_b_irq, match_a};

    // ======================================================================
    // mode register and interrupt state

    always @* begin
        mode_d = mode_q;
        mask_d = mask_q;
        // reserved write bits fall outside the register widths and are dropped
        if (wr_mode) begin
            mode_d = pwdata[`TCC_MODE_W-1:0];
        end
        if (wr_mask) begin
            mask_d = pwdata[`TCC_IRQ_W-1:0];
        end
        // a new event beats a write-one-to-clear in the same cycle
        stat_d = stat_q;
        if (wr_stat) begin
            stat_d = stat_q & ~pwdata[`TCC_IRQ_W-1:0];
        end
        stat_d = stat_d | events;
        // irq follows the next status, so it is high in the cycle the status reads set
        irq_d  = |(stat_d & mask_d);
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= `TCC_MODE_RST;
            stat_q <= `TCC_IRQ_RST;
            mask_q <= `TCC_IRQ_RST;
            irq_q  <= 1'b0;
        end else if (ce) begin
            mode_q <= mode_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            irq_q  <= irq_d;
        end
    end

    // ======================================================================
    // read mux: a read colliding with a capture returns the old value
    always @* begin
        prdata_d  = 32'h0000_0000;
        pslverr_d = ~is_mapped(paddr);
        pready_d  = answer;
        // writes answer with zero data
        if (!pwrite) begin
            case (paddr)
                `TCC_OFS_MODE:     prdata_d = {28'h000_0000, mode_q};
                `TCC_OFS_CC_A:     prdata_d = pad_word(cc_a_val);
                `TCC_OFS_CC_B:     prdata_d = pad_word(cc_b_val);
                `TCC_OFS_COUNT:    prdata_d = pad_word(count_q);
                `TCC_OFS_IRQ_STAT: prdata_d = {28'h000_0000, stat_q};
                `TCC_OFS_IRQ_MASK: prdata_d = {28'h000_0000, mask_q};
                default:           prdata_d = 32'h0000_0000;
            endcase
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (ce) begin
            pready_q <= pready_d;
            // outside the answer cycle the bus reads zero, never a stale word
            if (answer) begin
                prdata_q  <= prdata_d;
                pslverr_q <= pslverr_d;
            end else begin
                prdata_q  <= 32'h0000_0000;
                pslverr_q <= 1'b0;
            end
        end
    end

    // ======================================================================
    // outputs
    // every output leaves a flop, so nothing combinational reaches the bus
    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign irq     = irq_q;

endmodule // tcc_top

`default_nettype wire

// ==== rtl/tcc_timer_map.vh ====
// register map, field positions and reset values of the capture/compare timer
`ifndef TCC_TIMER_MAP_VH
`define TCC_TIMER_MAP_VH

// ==========================================================================
// register byte offsets
`define TCC_OFS_MODE       8'h00
`define TCC_OFS_CC_A       8'h04
`define TCC_OFS_CC_B       8'h08
`define TCC_OFS_COUNT      8'h0c
`define TCC_OFS_IRQ_STAT   8'h10
`define TCC_OFS_IRQ_MASK   8'h14

// ==========================================================================
// mode_control_reg fields
`define TCC_MODE_CAP_A     0
`define TCC_MODE_CAP_B     1
`define TCC_MODE_OP_LO     2
`define TCC_MODE_OP_HI     3
`define TCC_MODE_W         4

// ==========================================================================
// operating modes
`define TCC_OP_STOP        2'h0
`define TCC_OP_CLR_EDGE    2'h1
`define TCC_OP_FREE        2'h2
`define TCC_OP_CLR_MATCH   2'h3

// ==========================================================================
// interrupt status and mask fields
`define TCC_IRQ_MATCH_A    0
`define TCC_IRQ_MATCH_B    1
`define TCC_IRQ_CAP_A      2
`define TCC_IRQ_CAP_B      3
`define TCC_IRQ_W          4

// ==========================================================================
// reset values and counter limits
`define TCC_MODE_RST       4'h0
`define TCC_IRQ_RST        4'h0
`define TCC_CNT_ZERO       16'h0000
`define TCC_CNT_ONE        16'h0001
`define TCC_CNT_MAX        16'hffff

`endif

// ==== rtl/tcc_sync.v ====
// two-flop synchroniser with rising-edge detect for an external pin
`timescale 1ns/1ps
`default_nettype none

module tcc_sync (
    input  wire pclk,
    input  wire presetn,
    input  wire ce,
    input  wire pin,
    output wire rise
);

    // ======================================================================
    // synchroniser: first flop feeds only the second
    reg meta_q;
    reg sync_q;
    reg last_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else if (ce) begin
            meta_q <= pin;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign rise = sync_q & ~last_q;

endmodule // tcc_sync

`default_nettype wire

// ==== rtl/tcc_ccr.v ====
// one capture/compare register with its match detector
`timescale 1ns/1ps
`default_nettype none
`include "tcc_timer_map.vh"

module tcc_ccr #(
    parameter W = 16
) (
    input  wire         pclk,
    input  wire         presetn,
    input  wire         ce,
    input  wire         wr_en,
    input  wire [W-1:0] wdata,
    input  wire         cap_mode,
    input  wire         cap_trig,
    input  wire [W-1:0] count,
    input  wire         running,
    input  wire         wrapped,
    output wire [W-1:0] value,
    output wire         match,
    output wire         captured
);

    // ======================================================================
    // storage
    reg [W-1:0] value_q;

    // capture beats a coinciding write or read, so the edge is never lost
    assign captured = cap_mode & cap_trig;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value_q <= {W{1'b0}};
        end else if (ce) begin
            if (captured) begin
                value_q <= count;
            end else if (wr_en) begin
                value_q <= wdata;
            end
        end
    end

    assign value = value_q;

    // ======================================================================
    // match on reaching the compare value; zero only counts after a wrap
    // plain equality, so a value below the count waits for the wrap
    assign match = running & ~cap_mode & (count == value_q) &
                   ((value_q != {W{1'b0}}) | wrapped);

endmodule // tcc_ccr

`default_nettype wire

// ==== bench/tcc_top_monitor.sv ====
// assertion checker watching the timer's apb and interrupt ports
`timescale 1ns/1ps
`default_nettype none
module tcc_top_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        edge_input_a,
    input wire logic        irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==================================================
    // helper: last mode write left the counter stopped
    logic stop_q;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) stop_q <= 1'b1;
        else if (ce && pready && pwrite && paddr == 8'h00) stop_q <= (pwdata[3:2] == 2'h0);
    // ==================================================
    // handshake, decode, read data, irq masking and stopped count
    one_wait_a: assert property ($rose(penable) && psel && ce |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    ready_access_a: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    idle_bus_a: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("read data or error outside answer");
    decode_err_a: assert property (pready |-> pslverr == (paddr > 8'h14 || paddr[1:0] != 2'h0))
        else $error("error flag does not match decode");
    narrow_data_a: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0)
        else $error("reserved read bits not zero");
    mask_off_a: assert property (pready && pwrite && paddr == 8'h14 && pwdata[3:0] == 4'h0
        |-> ##[1:2] !irq) else $error("irq high with all sources masked");
    stop_count_a: assert property (pready && !pwrite && paddr == 8'h0c && stop_q |-> prdata == 32'h0)
        else $error("count not zero while stopped");
endmodule // tcc_top_monitor
bind tcc_top tcc_top_monitor u_tcc_top_monitor (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .edge_input_a(edge_input_a), .irq(irq));
`default_nettype wire

// ==== bench/tcc_cpu.sv ====
// processor model reaching the timer registers over apb
`timescale 1ns/1ps
`default_nettype none
module tcc_cpu (
    input  wire logic        pclk,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // ==================================================
    // one transfer; waits as long as the slave needs
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines flip so stale values are never mistaken for live ones
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule // tcc_cpu
`default_nettype wire

// ==== bench/tcc_top_bench.sv ====
// self-checking bench for the capture/compare timer
`timescale 1ns/1ps
`default_nettype none
`include "tcc_timer_map.vh"
module tcc_top_bench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        edge_input_a = 1'b0;
    logic        ce = 1'b1;
    logic        psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r1, r2;
    logic        e;
    int          err_count = 0;
    int          samples_checked = 0;
    always #12.5 pclk = ~pclk;
    tcc_cpu u_cpu (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    tcc_top u_tcc_top (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .edge_input_a(edge_input_a), .irq(irq));
    // ==================================================
    // helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_cpu.xfer(1'b1, a, d, r1, e);
    endtask
    task automatic rd(input logic [7:0] a);
        u_cpu.xfer(1'b0, a, 32'h0, r1, e);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(r1, exp);
    endtask
    task automatic conclude;
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // ==================================================
    // scenarios
    task automatic t_reset;
        rdchk(`TCC_OFS_MODE, 32'h0);
        rdchk(`TCC_OFS_IRQ_STAT, 32'h0);
        wr(`TCC_OFS_COUNT, 32'h5);
        rdchk(`TCC_OFS_COUNT, 32'h0);
        u_cpu.xfer(1'b0, 8'h18, 32'h0, r1, e);
        chk({e, r1[30:0]}, 32'h80000000);
    endtask
    task automatic t_modes;
        wr(`TCC_OFS_CC_A, 32'h100);
        for (int m = 1; m < 4; m++) begin
            wr(`TCC_OFS_MODE, 32'(m) << 2);
            rd(`TCC_OFS_COUNT);
            chk({31'h0, r1 != 32'h0}, 32'h1);
            wr(`TCC_OFS_MODE, 32'h0);
            rdchk(`TCC_OFS_COUNT, 32'h0);
        end
        wr(`TCC_OFS_MODE, 32'h8);
        rd(`TCC_OFS_COUNT);
        r2 = r1;
        rd(`TCC_OFS_COUNT);
        chk(r1 - r2, 32'h4);
        // ce low for ten edges must freeze the count
        r2 = r1;
        ce <= 1'b0;
        repeat (10) @(posedge pclk);
        ce <= 1'b1;
        rd(`TCC_OFS_COUNT);
        chk(r1 - r2, 32'h4);
        wr(`TCC_OFS_MODE, 32'h0);
    endtask
    task automatic t_match;
        wr(`TCC_OFS_IRQ_MASK, 32'h2);
        wr(`TCC_OFS_CC_B, 32'h3);
        wr(`TCC_OFS_MODE, 32'h8);
        repeat (10) @(posedge pclk);
        rd(`TCC_OFS_IRQ_STAT);
        chk(r1 & 32'h2, 32'h2);
        chk({31'h0, irq}, 32'h1);
        // a pending bit with its mask cleared must not drive the line
        wr(`TCC_OFS_IRQ_MASK, 32'h0);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        wr(`TCC_OFS_IRQ_MASK, 32'h2);
        rdchk(`TCC_OFS_IRQ_MASK, 32'h2);
        chk({31'h0, irq}, 32'h1);
        wr(`TCC_OFS_IRQ_STAT, 32'h2);
        rdchk(`TCC_OFS_IRQ_STAT, 32'h0);
        chk({31'h0, irq}, 32'h0);
        wr(`TCC_OFS_MODE, 32'h0);
    endtask
    task automatic t_capture;
        wr(`TCC_OFS_CC_B, 32'h1234);
        wr(`TCC_OFS_MODE, 32'h9);
        edge_input_a <= 1'b1;
        repeat (6) @(posedge pclk);
        edge_input_a <= 1'b0;
        rd(`TCC_OFS_IRQ_STAT);
        chk(r1 & 32'hc, 32'h4);
        rdchk(`TCC_OFS_CC_B, 32'h1234);
        rd(`TCC_OFS_CC_A);
        chk({31'h0, r1 != 32'h100}, 32'h1);
        wr(`TCC_OFS_MODE, 32'h0);
        wr(`TCC_OFS_IRQ_STAT, 32'hf);
    endtask
    task automatic t_wrap;
        wr(`TCC_OFS_CC_B, 32'h8000);
        wr(`TCC_OFS_MODE, 32'h8);
        repeat (40) @(posedge pclk);
        wr(`TCC_OFS_CC_B, 32'h2);
        repeat (20) @(posedge pclk);
        rd(`TCC_OFS_IRQ_STAT);
        chk(r1 & 32'h2, 32'h0);
        // a zero compare point does not match on restart, only once the count wraps
        wr(`TCC_OFS_MODE, 32'h0);
        wr(`TCC_OFS_CC_B, 32'h0);
        wr(`TCC_OFS_MODE, 32'h8);
        repeat (40) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        for (int i = 0; i < 70000 && irq !== 1'b1; i++) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        rd(`TCC_OFS_COUNT);
        chk({31'h0, r1 < 32'h10}, 32'h1);
        wr(`TCC_OFS_MODE, 32'h0);
    endtask
    // ==================================================
    // main sequence and watchdog
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_modes();
        t_match();
        t_capture();
        t_wrap();
        conclude();
    end
    initial begin
        #(90000 * 25);
        err_count++;
        conclude();
    end
endmodule // tcc_top_bench
`default_nettype wire
